// ---- dv/alc_gain_ctrl_tb_top.sv ----
// self-checking testbench of the automatic level control sequencer
`timescale 1ns/100ps
module alc_gain_ctrl_tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [8:0] reg_wdata_i = 9'h000;
  logic sample_tick_i = 1'b0;
  logic level_above_i = 1'b0;
  logic level_below_i = 1'b0;
  logic zero_cross_i = 1'b0;
  logic [8:0] reg_rdata_o;
  logic [5:0] input_amp_volume_o;
  logic input_amp_mute_o;
  logic level_ctrl_enable_o;
  int err_count = 0;
  int num_checks = 0;
  int seed = 92635;
  int gap = 2;
  int model_gain = 16;
  int g;
  bit tick_on = 1'b0;

  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;

  alc_gain_ctrl i_alc_gain_ctrl (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .sample_tick_i(sample_tick_i),
    .level_above_i(level_above_i),
    .level_below_i(level_below_i),
    .zero_cross_i(zero_cross_i),
    .reg_rdata_o(reg_rdata_o),
    .input_amp_volume_o(input_amp_volume_o),
    .input_amp_mute_o(input_amp_mute_o),
    .level_ctrl_enable_o(level_ctrl_enable_o)
  );

  // sample ticks with random spacing of 3 to 5 cycles, so no tick lands on a step edge
  always begin
    @(posedge mclk_i);
    #2;
    if (tick_on && gap == 0) begin
      sample_tick_i = 1'b1;
      gap = 2 + ($unsigned($random(seed)) % 3);
    end else begin
      sample_tick_i = 1'b0;
      if (gap > 0) gap--;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle write strobe; tasks start and end 2 ns after an edge
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge mclk_i);
    #2;
    reg_wr_i = 1'b0;
    // one idle edge, so a following write never re-raises the strobe in this time step
    @(posedge mclk_i);
    #2;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] exp, input string name);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge mclk_i);
    #2;
    reg_rd_i = 1'b0;
    @(posedge mclk_i);
    #2;
    chk(name, {7'h00, exp}, {7'h00, reg_rdata_o});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  // level requests change with ticks stopped, so the timer restart never eats a tick
  task automatic lvl(input logic a, input logic b);
    level_above_i = a;
    level_below_i = b;
    idle(2);
  endtask

  task automatic chk_vol(input string name);
    chk(name, 16'(model_gain), {10'h000, input_amp_volume_o});
  endtask

  // counts ticks until the gain moves, then compares count and new gain with the model
  task automatic wait_step(input int n, input int dir);
    int ticks;
    int t;
    logic [5:0] g0;
    ticks = 0;
    t = 0;
    g0 = input_amp_volume_o;
    tick_on = 1'b1;
    while (input_amp_volume_o === g0 && t < 20000) begin
      @(posedge mclk_i);
      #1;
      t++;
      if (sample_tick_i === 1'b1) ticks++;
    end
    tick_on = 1'b0;
    model_gain += dir;
    chk("step ticks", 16'(n), 16'(ticks));
    chk_vol("gain after step");
    #1;
  endtask

  // ticks run for a while with no step expected
  task automatic hold_run(input int n);
    tick_on = 1'b1;
    repeat (n) @(posedge mclk_i);
    tick_on = 1'b0;
    #2;
  endtask

  // watchdog: the sequence needs about 4500 cycles, the longest step near 4100
  initial begin
    #(25 * 40000);
    err_count++;
    $display("unexpected run length: expected end of tests, seen watchdog expiry");
    final_report();
  end

  initial begin
    idle(4);
    resetn_i = 1'b1;
    chk("volume reset", 16'h0010, {10'h000, input_amp_volume_o});
    chk("mute reset", 16'h0000, {15'h0000, input_amp_mute_o});
    chk("enable reset", 16'h0000, {15'h0000, level_ctrl_enable_o});
    rd(7'h20, 9'h038, "cfg1 reset");
    rd(7'h22, 9'h032, "cfg3 reset");
    rd(7'h2A, 9'h000, "cfg4 reset");
    rd(7'h2D, 9'h010, "volume reg reset");
    wr(7'h11, 9'h1FF);
    rd(7'h11, 9'h000, "unmapped read");
    // normal mode, fastest codes, start at 0x20 with mute cleared before enabling
    wr(7'h22, 9'h000);
    wr(7'h2D, 9'h020);
    model_gain = 32;
    wr(7'h20, 9'h138);
    chk("enable", 16'h0001, {15'h0000, level_ctrl_enable_o});
    lvl(1'b1, 1'b0);
    wait_step(5, -1);
    wait_step(5, -1);
    lvl(1'b0, 1'b1);
    wait_step(18, 1);
    lvl(1'b0, 1'b0);
    // switch to limiter while running: start level becomes 0x1F
    wr(7'h22, 9'h110);
    rd(7'h22, 9'h110, "cfg3 limiter");
    lvl(1'b1, 1'b0);
    wait_step(1, -1);
    wait_step(1, -1);
    lvl(1'b0, 1'b0);
    wait_step(8, 1);
    wait_step(8, 1);
    hold_run(60);
    chk_vol("limiter top");
    // attack code above 1010 saturates at the 1010 step time
    wr(7'h22, 9'h11C);
    lvl(1'b1, 1'b0);
    wait_step(1024, -1);
    // zero-cross gating holds the pending step until a crossing
    wr(7'h22, 9'h110);
    wr(7'h2A, 9'h002);
    rd(7'h2A, 9'h002, "cfg4 zero cross");
    hold_run(30);
    chk_vol("gain waits for crossing");
    zero_cross_i = 1'b1;
    idle(1);
    zero_cross_i = 1'b0;
    idle(1);
    model_gain--;
    chk_vol("gain at crossing");
    wr(7'h2A, 9'h000);
    lvl(1'b0, 1'b0);
    // a volume write while enabled leaves the gain to the controller
    wr(7'h2D, 9'h005);
    rd(7'h2D, 9'(model_gain), "live gain readback");
    // disable: gain stays put until software writes it
    wr(7'h20, 9'h038);
    chk("disable", 16'h0000, {15'h0000, level_ctrl_enable_o});
    lvl(1'b1, 1'b0);
    hold_run(30);
    chk_vol("gain held when disabled");
    lvl(1'b0, 1'b0);
    wr(7'h2D, 9'h00A);
    model_gain = 10;
    idle(1);
    chk_vol("gain written");
    wr(7'h2D, 9'h04A);
    chk("mute set", 16'h0001, {15'h0000, input_amp_mute_o});
    wr(7'h2D, 9'h00A);
    // random start gain below the floor, then above the ceiling, is pulled into range;
    // normal mode, since a limiter start below the floor leaves no legal gain
    wr(7'h22, 9'h010);
    for (int i = 0; i < 2; i++) begin
      g = (i == 0) ? ($unsigned($random(seed)) % 24) : (32 + $unsigned($random(seed)) % 32);
      wr(7'h2D, 9'(g));
      wr(7'h20, (i == 0) ? 9'h13B : 9'h118);
      idle(3);
      model_gain = (i == 0) ? 24 : 31;
      chk_vol("gain clamped");
      wr(7'h20, 9'h038);
    end
    final_report();
  end
endmodule // alc_gain_ctrl_tb_top

// ---- src/alc_gain_ctrl.sv ----
// automatic level control sequencer for the input amplifier gain
`timescale 1ns/100ps
module alc_gain_ctrl (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic sample_tick_i,
  input wire logic level_above_i,
  input wire logic level_below_i,
  input wire logic zero_cross_i,
  output logic [8:0] reg_rdata_o,
  output logic [5:0] input_amp_volume_o,
  output logic input_amp_mute_o,
  output logic level_ctrl_enable_o
);

  alc_pkg::alc_core_state_type r_reg;
  alc_pkg::alc_core_state_type r_next;

  // per-step period in sample ticks for a mode, direction and code
  function automatic logic [alc_pkg::CNT_W-1:0] step_samples(
    input logic limiter,
    input logic down,
    input logic [3:0] code
  );
    logic [3:0] sh;
    logic [alc_pkg::CNT_W-1:0] base;
    sh = (code > alc_pkg::CODE_SAT) ? alc_pkg::CODE_SAT : code;
    if (down) begin
      base = limiter ? alc_pkg::CNT_W'(alc_pkg::ATK_LIM_SMP)
                     : alc_pkg::CNT_W'(alc_pkg::ATK_NORM_SMP);
    end else begin
      base = limiter ? alc_pkg::CNT_W'(alc_pkg::DCY_LIM_SMP)
                     : alc_pkg::CNT_W'(alc_pkg::DCY_NORM_SMP);
    end
    return base << sh;
  endfunction

  // register writes decoded in one place
  function automatic logic wr_hit(
    input logic wr,
    input logic [6:0] addr,
    input logic [6:0] target
  );
    return wr && (addr == target);
  endfunction

  // gain limits derived from the floor and ceiling codes
  logic [5:0] floor_gain;
  logic [5:0] ceil_gain;
  logic [5:0] top_gain;
  logic in_range;
  logic want_down;
  logic want_up;
  logic dir_down;
  logic timer_restart;
  logic step_done;
  logic vol_wr;
  logic [alc_pkg::CNT_W-1:0] step_limit;

  // in limiter mode the upper bound is the lower of ceiling and starting level
  // limitation: a starting level below the floor leaves no legal gain, so keep it inside
  always_comb begin
    floor_gain = {r_reg.floor_code, alc_pkg::FLOOR_FRAC};
    ceil_gain = {r_reg.ceil_code, alc_pkg::CEIL_FRAC};
    top_gain = ceil_gain;
    if (r_reg.limiter && (r_reg.start_gain < ceil_gain)) begin
      top_gain = r_reg.start_gain;
    end
    in_range = (r_reg.gain >= floor_gain) && (r_reg.gain <= top_gain);
  end

  // step direction requests from the level detector
  always_comb begin
    want_down = r_reg.enable && level_above_i && (r_reg.gain > floor_gain);
    if (r_reg.limiter) begin
      want_up = r_reg.enable && !level_above_i && (r_reg.gain < top_gain);
    end else begin
      // normal mode tracks target both ways
      want_up = r_reg.enable && level_below_i && !level_above_i && (r_reg.gain < top_gain);
    end
    dir_down = want_down;
    // restart pacing when idle, out of range, or the direction flips
    timer_restart = !(want_down || want_up) || !in_range
                    || (dir_down != r_reg.last_down) || (r_reg.st != alc_pkg::ALC_RUN);
  end

  always_comb begin
    // attack period, decay period, mode sets meaning
    step_limit = step_samples(r_reg.limiter, dir_down, dir_down ? r_reg.atk : r_reg.dcy);
  end

  assign vol_wr = wr_hit(reg_wr_i, reg_addr_i, alc_pkg::INPUT_AMP_VOLUME_ADDR);

  alc_step_timer i_alc_step_timer (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .restart_i(timer_restart),
    .tick_i(sample_tick_i),
    .limit_i(step_limit),
    .done_o(step_done)
  );

  // register file, capture of starting level, and the gain sequencer
  always_comb begin
    r_next = r_reg;
    r_next.last_down = dir_down;

    // control register writes
    if (wr_hit(reg_wr_i, reg_addr_i, alc_pkg::LEVEL_CONTROL_CFG1_ADDR)) begin
      r_next.floor_code = reg_wdata_i[alc_pkg::FLOOR_LSB +: 3];
      r_next.ceil_code = reg_wdata_i[alc_pkg::CEIL_LSB +: 3];
      r_next.enable = reg_wdata_i[alc_pkg::ENABLE_BIT];
      // capture start on any enable, whichever the mode
      if (!r_reg.enable && reg_wdata_i[alc_pkg::ENABLE_BIT]) begin
        r_next.start_gain = r_reg.gain;
      end
    end
    if (wr_hit(reg_wr_i, reg_addr_i, alc_pkg::LEVEL_CONTROL_CFG3_ADDR)) begin
      r_next.limiter = reg_wdata_i[alc_pkg::LIMITER_BIT];
      r_next.dcy = reg_wdata_i[alc_pkg::DCY_LSB +: 4];
      r_next.atk = reg_wdata_i[alc_pkg::ATK_LSB +: 4];
      if (r_reg.enable && !r_reg.limiter && reg_wdata_i[alc_pkg::LIMITER_BIT]) begin
        r_next.start_gain = r_reg.gain;
      end
    end
    if (wr_hit(reg_wr_i, reg_addr_i, alc_pkg::LEVEL_CONTROL_CFG4_ADDR)) begin
      r_next.zc_en = reg_wdata_i[alc_pkg::ZC_BIT];
    end
    if (vol_wr) begin
      // mute is software's to clear before enabling
      r_next.mute = reg_wdata_i[alc_pkg::MUTE_BIT];
      // software volume only lands while control is off
      if (!r_reg.enable) begin
        r_next.gain = reg_wdata_i[alc_pkg::VOL_LSB +: 6];
      end
    end

    // readback; the volume address shows the live gain
    if (reg_rd_i) begin
      case (reg_addr_i)
        alc_pkg::LEVEL_CONTROL_CFG1_ADDR: begin
          r_next.rdata = {r_reg.enable, 2'h0, r_reg.ceil_code, r_reg.floor_code};
        end
        alc_pkg::LEVEL_CONTROL_CFG3_ADDR: begin
          r_next.rdata = {r_reg.limiter, r_reg.dcy, r_reg.atk};
        end
        alc_pkg::LEVEL_CONTROL_CFG4_ADDR: begin
          r_next.rdata = {7'h00, r_reg.zc_en, 1'b0};
        end
        alc_pkg::INPUT_AMP_VOLUME_ADDR: begin
          r_next.rdata = {2'h0, r_reg.mute, r_reg.gain};
        end
        default: begin
          r_next.rdata = alc_pkg::RDATA_RST;
        end
      endcase
    end

    // sequencer
    case (r_reg.st)
      alc_pkg::ALC_OFF: begin
        // gain left where the controller put it
        if (r_reg.enable) begin
          r_next.st = alc_pkg::ALC_RUN;
        end
      end
      alc_pkg::ALC_RUN: begin
        if (!r_reg.enable) begin
          r_next.st = alc_pkg::ALC_OFF;
        end else if (r_reg.gain > top_gain) begin
          // pull back to the upper bound at once
          r_next.gain = top_gain;
        end else if (r_reg.gain < floor_gain) begin
          // pull back to the floor at once
          r_next.gain = floor_gain;
        end else if (step_done && (want_down || want_up)) begin
          if (r_reg.zc_en) begin
            // hold the step until a zero crossing
            r_next.pend_down = want_down;
            r_next.st = alc_pkg::ALC_WAIT_ZC;
          end else if (want_down) begin
            r_next.gain = r_reg.gain - 6'h01;
          end else begin
            r_next.gain = r_reg.gain + 6'h01;
          end
        end
      end
      alc_pkg::ALC_WAIT_ZC: begin
        // a disable drops the pending step; a crossing applies it if still legal
        if (!r_reg.enable) begin
          r_next.st = alc_pkg::ALC_OFF;
        end else if (!in_range) begin
          r_next.st = alc_pkg::ALC_RUN;
        end else if (zero_cross_i) begin
          r_next.st = alc_pkg::ALC_RUN;
          if (r_reg.pend_down && (r_reg.gain > floor_gain)) begin
            r_next.gain = r_reg.gain - 6'h01;
          end else if (!r_reg.pend_down && (r_reg.gain < top_gain)) begin
            r_next.gain = r_reg.gain + 6'h01;
          end
        end
      end
      default: begin
        r_next.st = alc_pkg::ALC_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      r_reg.st <= alc_pkg::ALC_OFF;
      r_reg.enable <= 1'b0;
      r_reg.limiter <= 1'b0;
      r_reg.floor_code <= alc_pkg::FLOOR_RST;
      r_reg.ceil_code <= alc_pkg::CEIL_RST;
      r_reg.atk <= alc_pkg::ATK_RST;
      r_reg.dcy <= alc_pkg::DCY_RST;
      r_reg.zc_en <= 1'b0;
      r_reg.gain <= alc_pkg::VOL_RST;
      r_reg.mute <= 1'b0;
      r_reg.start_gain <= alc_pkg::VOL_RST;
      r_reg.pend_down <= 1'b0;
      r_reg.last_down <= 1'b0;
      r_reg.rdata <= alc_pkg::RDATA_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = r_reg.rdata;
  assign input_amp_volume_o = r_reg.gain;
  assign input_amp_mute_o = r_reg.mute;
  assign level_ctrl_enable_o = r_reg.enable;

  limiter_cap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && r_reg.limiter && $past(r_reg.enable) && $past(r_reg.limiter)
      |-> r_reg.gain <= r_reg.start_gain)
    else $error("limiter gain above starting level");

  enable_capture_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(r_reg.enable) |-> r_reg.start_gain == $past(r_reg.gain))
    else $error("starting level not captured at enable");

  switch_capture_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $past(r_reg.enable) && r_reg.enable && $rose(r_reg.limiter)
      |-> r_reg.start_gain == $past(r_reg.gain))
    else $error("starting level not captured at switchover");

  off_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !r_reg.enable && !vol_wr ##1 !r_reg.enable |-> $stable(r_reg.gain))
    else $error("gain moved while control disabled");

  step_size_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && in_range && (r_reg.st != alc_pkg::ALC_OFF) ##1 r_reg.enable
      |-> (r_reg.gain == $past(r_reg.gain)) || (r_reg.gain == $past(r_reg.gain) + 6'h01)
          || (r_reg.gain == $past(r_reg.gain) - 6'h01))
    else $error("gain step larger than one increment");

  floor_clamp_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && (r_reg.st == alc_pkg::ALC_RUN) && (r_reg.gain < floor_gain)
      && (floor_gain <= top_gain) |=> r_reg.gain == $past(floor_gain))
    else $error("gain below floor not corrected");

  top_clamp_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && (r_reg.st == alc_pkg::ALC_RUN) && (r_reg.gain > top_gain)
      |=> r_reg.gain == $past(top_gain))
    else $error("gain above bound not corrected");

  zc_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && r_reg.zc_en && in_range && !zero_cross_i ##1 r_reg.enable
      |-> $stable(r_reg.gain))
    else $error("gain stepped without zero crossing");

  attack_dir_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && in_range && (r_reg.st == alc_pkg::ALC_RUN) && !level_above_i
      |=> r_reg.gain >= $past(r_reg.gain))
    else $error("gain cut without a peak");

  decay_dir_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    r_reg.enable && in_range && (r_reg.st == alc_pkg::ALC_RUN) && level_above_i
      |=> r_reg.gain <= $past(r_reg.gain))
    else $error("gain raised during a peak");

endmodule // alc_gain_ctrl

// ---- src/alc_pkg.sv ----
// constants, types and register layout of the automatic level control sequencer
// Overview of operation
// - In normal mode the gain is stepped up or down continuously so the level stays at target.
// - In limiter mode the gain is only cut for peaks and never rises above a starting level that is at or above the floor.
// - The limiter starting level is the gain captured when control is enabled in limiter mode.
// - Switching from normal to limiter while running captures the gain at the switchover.
// - With control disabled the gain stays at its last value until software writes a new one.
// - Attack governs gain cuts; normal mode is 104us per step at code 0, doubling, 106ms from 10.
// - Limiter attack is 22.7us per step at code 0, doubling, saturating at 23.2ms from code 10.
// - Decay governs gain rises and doubles per code to code 10: 420ms normal, 90.8us to 93ms limiter.
// - Zero-cross enable at bit 1, reset 0, makes gain steps wait for a signal zero crossing; range corrections do not wait.
// - All step times are counted in audio sample periods, so they scale with the sample rate.
// - The mode bit selects normal operation at 0 and limiter operation at 1.
// - The enable bit turns automatic gain control off at 0 and on at 1.
// - While control is enabled, a gain outside the floor to ceiling range is moved back into range at once.
package alc_pkg;

  // register offsets on the control port
  localparam logic [6:0] LEVEL_CONTROL_CFG1_ADDR = 7'h20;
  localparam logic [6:0] LEVEL_CONTROL_CFG3_ADDR = 7'h22;
  localparam logic [6:0] LEVEL_CONTROL_CFG4_ADDR = 7'h2A;
  localparam logic [6:0] INPUT_AMP_VOLUME_ADDR = 7'h2D;

  // field positions
  localparam int FLOOR_LSB = 0;
  localparam int CEIL_LSB = 3;
  localparam int ENABLE_BIT = 8;
  localparam int ATK_LSB = 0;
  localparam int DCY_LSB = 4;
  localparam int LIMITER_BIT = 8;
  localparam int ZC_BIT = 1;
  localparam int VOL_LSB = 0;
  localparam int MUTE_BIT = 6;

  // reset values
  localparam logic [2:0] FLOOR_RST = 3'h0;
  localparam logic [2:0] CEIL_RST = 3'h7;
  localparam logic [3:0] ATK_RST = 4'h2;
  localparam logic [3:0] DCY_RST = 4'h3;
  localparam logic [5:0] VOL_RST = 6'h10;
  localparam logic [8:0] RDATA_RST = 9'h000;

  // gain code layout: 0.75dB per increment, eight per 6dB band
  localparam logic [2:0] FLOOR_FRAC = 3'h0;
  localparam logic [2:0] CEIL_FRAC = 3'h7;

  // step times in ns as printed, converted to sample periods at the reference rate
  localparam int SAMPLE_PERIOD_NS = 22676;
  localparam int ATK_NORM_NS = 104000;
  localparam int ATK_LIM_NS = 22700;
  localparam int DCY_NORM_NS = 410000;
  localparam int DCY_LIM_NS = 90800;
  localparam int ATK_NORM_SMP = (ATK_NORM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
  localparam int ATK_LIM_SMP = (ATK_LIM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
  localparam int DCY_NORM_SMP = (DCY_NORM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
  localparam int DCY_LIM_SMP = (DCY_LIM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
  localparam logic [3:0] CODE_SAT = 4'hA;
  localparam int CNT_W = 20;

  // sequencer states
  typedef enum logic [1:0] {
    ALC_OFF,
    ALC_RUN,
    ALC_WAIT_ZC
  } alc_st_type;

  // step timer state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } alc_tmr_state_type;

  // sequencer state
  typedef struct packed {
    alc_st_type st;
    logic enable;
    logic limiter;
    logic [2:0] floor_code;
    logic [2:0] ceil_code;
    logic [3:0] atk;
    logic [3:0] dcy;
    logic zc_en;
    logic [5:0] gain;
    logic mute;
    logic [5:0] start_gain;
    logic pend_down;
    logic last_down;
    logic [8:0] rdata;
  } alc_core_state_type;

endpackage

// ---- src/alc_step_timer.sv ----
// sample-tick step timer for attack and decay pacing
`timescale 1ns/100ps
module alc_step_timer (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic restart_i,
  input wire logic tick_i,
  input wire logic [alc_pkg::CNT_W-1:0] limit_i,
  output logic done_o
);

  alc_pkg::alc_tmr_state_type r_reg;
  alc_pkg::alc_tmr_state_type r_next;

  // count sample ticks, pulse done when the step period has elapsed
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (restart_i) begin
      r_next.cnt = '0;
    end else if (tick_i) begin
      if (r_reg.cnt + 1'b1 >= limit_i) begin
        r_next.cnt = '0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_o = r_reg.done;

  timer_tick_only_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    done_o |-> $past(tick_i) && !$past(restart_i))
    else $error("step done without a sample tick");

endmodule // alc_step_timer
